/* File: hdl/timer16_core.v */
// Purpose: 16-bit timer/counter with byte-wise atomic access over APB
// Assumes: single clock pclk at 40 MHz, pins asynchronous
// Notes:   up-counting only; waveform pins toggle on match
// What this block does
// - ceiling is 0x00FF, 0x01FF, 0x03FF, compare A or capture, by mode
// - bottom is signalled when the counter wraps from the ceiling to zero
// - max is signalled when the counter steps from all ones back to zero
// - one shared 8-bit high-byte holding register for all 16-bit registers
// - low-byte write loads holding byte plus written byte at once
// - low-byte read of counter or capture copies its high byte to holding
// - compare reads return both bytes directly, holding untouched
// - counter is frozen when no clock source is selected
// - tick comes from prescaler or external pin with chosen edge
// - both compare registers are compared with the counter continuously
// - a compare match sets that channel's match flag
// - pin or comparator edge copies the counter into capture register
// - optional noise filter on the capture input
// - compare A as ceiling drives no waveform and stays double buffered
// - four flags in one flag register, each gated by a mask bit
// - timer works only while its power-off bit is zero
// - control registers A and B are plain byte read/write; C writes force toggles and reads as zero
// - software counter write beats count or clear in that cycle
// - capture flag sets in the same cycle as the capture copy
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "timer16_defs.vh"
module timer16_core
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        capture_input_pin,
  input  wire        comparator_out,
  input  wire        ext_count_pin,
  output reg         wave_out_a,
  output reg         wave_out_b,
  output wire        irq
);
  //==========================================================
  // registers
  reg  [7:0]  control_reg_a;
  reg  [7:0]  control_reg_b;
  reg  [7:0]  control_reg_c;
  reg  [15:0] count_value;
  reg  [15:0] compare_a_value;
  reg  [15:0] compare_b_value;
  reg  [15:0] compare_a_buf_r;
  reg  [15:0] compare_b_buf_r;
  reg  [15:0] capture_value;
  reg  [7:0]  hold_r;
  reg  [3:0]  irq_flag_reg;
  reg  [3:0]  irq_mask_reg;
  reg         timer_power_off_bit;
  reg  [9:0]  presc_r;
  reg  [3:0]  filt_r;
  reg         filt_lvl_r;
  reg         cap_prev_r;
  reg  [31:0] rdata_r;
  wire        wr;
  wire        rd;
  wire        run;
  wire [2:0]  clk_sel;
  wire [1:0]  wave_mode;
  wire        ext_rise;
  wire        ext_fall;
  wire        pin_lvl;
  wire        cap_raw;
  wire        cap_src;
  wire        cap_event;
  wire        cap_now;
  reg         tick;
  reg  [15:0] ceiling;
  reg  [7:0]  rbyte;
  wire        at_top;
  wire        match_a;
  wire        match_b;

  assign wr        = psel & penable & pwrite;
  // reads act at the setup edge, so the held high byte and the low byte come from one snapshot
  assign rd        = psel & ~penable & ~pwrite;
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign prdata    = rdata_r;
  assign run       = ~timer_power_off_bit & ce;
  assign clk_sel   = control_reg_b[`CS_MSB:`CS_LSB];
  assign wave_mode = control_reg_b[`WM_MSB:`WM_LSB];
  assign irq       = |(irq_flag_reg & irq_mask_reg);

  //==========================================================
  // pin synchronisers
  edge_sync u_ext_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (ext_count_pin),
    .level   (),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  edge_sync u_cap_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (capture_input_pin),
    .level   (pin_lvl),
    .rise    (),
    .fall    ()
  );

  edge_sync u_cmp_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (comparator_out),
    .level   (cap_raw),
    .rise    (),
    .fall    ()
  );

  //==========================================================
  // tick selection
  always @*
  begin
    case (clk_sel)
      `CS_OFF:      tick = 1'b0;
      `CS_DIV1:     tick = 1'b1;
      `CS_DIV8:     tick = (presc_r[2:0] == 3'h7);
      `CS_DIV64:    tick = (presc_r[5:0] == 6'h3F);
      `CS_DIV256:   tick = (presc_r[7:0] == 8'hFF);
      `CS_DIV1024:  tick = (presc_r == `PRESCALE_MAX);
      `CS_EXT_FALL: tick = ext_fall;
      `CS_EXT_RISE: tick = ext_rise;
      default:      tick = 1'b0;
    endcase
  end

  //==========================================================
  // ceiling and matches
  always @*
  begin
    case (wave_mode)
      `WM_FIX8:    ceiling = `CEIL_FIX8;
      `WM_FIX9:    ceiling = `CEIL_FIX9;
      `WM_FIX10:   ceiling = `CEIL_FIX10;
      `WM_TOP_VAR: ceiling = control_reg_b[`BIT_CAP_SRC] ? capture_value : compare_a_value;
      default:     ceiling = `CEIL_FIX8;
    endcase
  end

  assign at_top  = (count_value == ceiling);
  assign match_a = (count_value == compare_a_value);
  assign match_b = (count_value == compare_b_value);

  //==========================================================
  // capture filter: level must agree for FILTER_LEN samples
  assign cap_src   = control_reg_b[`BIT_CAP_SRC] ? cap_raw : pin_lvl;
  assign cap_now   = control_reg_b[`BIT_CAP_FILTER] ? filt_lvl_r : cap_src;
  assign cap_event = (cap_now != cap_prev_r) &
                     (cap_now == control_reg_b[`BIT_CAP_EDGE]);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_r     <= 4'h0;
      filt_lvl_r <= 1'b0;
      cap_prev_r <= 1'b0;
      presc_r    <= 10'h000;
    end
    else if (run)
    begin
      filt_r     <= {filt_r[`FILTER_LEN-2:0], cap_src};
      if (&filt_r)
        filt_lvl_r <= 1'b1;
      else if (~|filt_r)
        filt_lvl_r <= 1'b0;
      cap_prev_r <= cap_now;
      presc_r    <= presc_r + 10'h001;
    end
  end

  //==========================================================
  // main register process
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_reg_a       <= `RESET_BYTE;
      control_reg_b       <= `RESET_BYTE;
      control_reg_c       <= `RESET_BYTE;
      count_value         <= `RESET_WORD;
      compare_a_value     <= `RESET_WORD;
      compare_b_value     <= `RESET_WORD;
      compare_a_buf_r     <= `RESET_WORD;
      compare_b_buf_r     <= `RESET_WORD;
      capture_value       <= `RESET_WORD;
      hold_r              <= `RESET_BYTE;
      irq_flag_reg        <= 4'h0;
      irq_mask_reg        <= 4'h0;
      timer_power_off_bit <= `POWER_RESET;
      wave_out_a          <= 1'b0;
      wave_out_b          <= 1'b0;
    end
    else if (ce)
    begin
      control_reg_c <= `RESET_BYTE;
      // counting, frozen when powered off
      if (run && tick)
      begin
        if (at_top)
        begin
          count_value     <= `CNT_BOTTOM;
          // compare registers update at the top, avoiding glitches mid-period
          compare_a_value <= compare_a_buf_r;
          compare_b_value <= compare_b_buf_r;
        end
        else
          count_value <= count_value + 16'h0001;
      end
      // flags: hardware set wins over software clear
      if (wr && paddr == `OFS_FLAG)
        irq_flag_reg <= irq_flag_reg & ~pwdata[3:0];
      if (run && tick && (at_top || count_value == `CNT_MAX))
        irq_flag_reg[`BIT_OVF] <= 1'b1;
      // matches count only on a tick, so a stopped counter cannot re-set a cleared flag
      if (run && tick && match_a)
        irq_flag_reg[`BIT_MATCH_A] <= 1'b1;
      if (run && tick && match_b)
        irq_flag_reg[`BIT_MATCH_B] <= 1'b1;
      if (run && cap_event)
      begin
        capture_value                <= count_value;
        irq_flag_reg[`BIT_CAPTURE]   <= 1'b1;
      end
      // waveform toggles on a fresh match when the counter steps
      if (run && tick && match_a && wave_mode != `WM_TOP_VAR)
        wave_out_a <= ~wave_out_a;
      if (run && tick && match_b)
        wave_out_b <= ~wave_out_b;
      // bus writes
      if (wr)
      begin
        case (paddr)
          `OFS_CTRL_A: control_reg_a <= pwdata[7:0];
          `OFS_CTRL_B: control_reg_b <= pwdata[7:0];
          `OFS_CTRL_C:
          begin
            if (pwdata[`BIT_FORCE_A] && wave_mode != `WM_TOP_VAR)
              wave_out_a <= ~wave_out_a;
            if (pwdata[`BIT_FORCE_B])
              wave_out_b <= ~wave_out_b;
          end
          `OFS_CNT_H,
          `OFS_CMPA_H,
          `OFS_CMPB_H,
          `OFS_CAP_H:  hold_r <= pwdata[7:0];
          `OFS_CNT_L:  count_value <= {hold_r, pwdata[7:0]};
          `OFS_CMPA_L: compare_a_buf_r <= {hold_r, pwdata[7:0]};
          `OFS_CMPB_L: compare_b_buf_r <= {hold_r, pwdata[7:0]};
          `OFS_CAP_L:  capture_value <= {hold_r, pwdata[7:0]};
          `OFS_MASK:   irq_mask_reg <= pwdata[3:0];
          `OFS_POWER:  timer_power_off_bit <= pwdata[0];
          default:     hold_r <= hold_r;
        endcase
      end
      if (rd && paddr == `OFS_CNT_L)
        hold_r <= count_value[15:8];
      if (rd && paddr == `OFS_CAP_L)
        hold_r <= capture_value[15:8];
    end
  end

  //==========================================================
  // read data; compare reads bypass the holding byte
  always @*
  begin
    case (paddr)
      `OFS_CTRL_A: rbyte = control_reg_a;
      `OFS_CTRL_B: rbyte = control_reg_b;
      `OFS_CTRL_C: rbyte = `RESET_BYTE;
      `OFS_CNT_L:  rbyte = count_value[7:0];
      `OFS_CNT_H:  rbyte = hold_r;
      `OFS_CMPA_L: rbyte = compare_a_buf_r[7:0];
      `OFS_CMPA_H: rbyte = compare_a_buf_r[15:8];
      `OFS_CMPB_L: rbyte = compare_b_buf_r[7:0];
      `OFS_CMPB_H: rbyte = compare_b_buf_r[15:8];
      `OFS_CAP_L:  rbyte = capture_value[7:0];
      `OFS_CAP_H:  rbyte = hold_r;
      `OFS_FLAG:   rbyte = {4'h0, irq_flag_reg};
      `OFS_MASK:   rbyte = {4'h0, irq_mask_reg};
      `OFS_POWER:  rbyte = {7'h00, timer_power_off_bit};
      default:     rbyte = `RESET_BYTE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_r <= 32'h0000_0000;
    else if (ce && psel && !penable && !pwrite)
      rdata_r <= {24'h00_0000, rbyte};
  end
endmodule // timer16_core

/* File: hdl/timer16_defs.vh */
// Purpose: shared constants for the 16-bit timer core
// Assumes: byte-wide registers, one per aligned APB word
// Notes:   offsets are byte addresses
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
`define OFS_CTRL_A      12'h000
`define OFS_CTRL_B      12'h004
`define OFS_CTRL_C      12'h008
`define OFS_CNT_L       12'h00C
`define OFS_CNT_H       12'h010
`define OFS_CMPA_L      12'h014
`define OFS_CMPA_H      12'h018
`define OFS_CMPB_L      12'h01C
`define OFS_CMPB_H      12'h020
`define OFS_CAP_L       12'h024
`define OFS_CAP_H       12'h028
`define OFS_FLAG        12'h02C
`define OFS_MASK        12'h030
`define OFS_POWER       12'h034
// flag and mask bit positions
`define BIT_OVF         0
`define BIT_MATCH_A     1
`define BIT_MATCH_B     2
`define BIT_CAPTURE     3
// control_reg_b fields
`define CS_LSB          0
`define CS_MSB          2
`define WM_LSB          3
`define WM_MSB          4
`define BIT_CAP_EDGE    5
`define BIT_CAP_FILTER  6
`define BIT_CAP_SRC     7
// control_reg_c fields
`define BIT_FORCE_A     0
`define BIT_FORCE_B     1
// clock select codes
`define CS_OFF          3'h0
`define CS_DIV1         3'h1
`define CS_DIV8         3'h2
`define CS_DIV64        3'h3
`define CS_DIV256       3'h4
`define CS_DIV1024      3'h5
`define CS_EXT_FALL     3'h6
`define CS_EXT_RISE     3'h7
// ceiling modes
`define WM_FIX8         2'h0
`define WM_FIX9         2'h1
`define WM_FIX10        2'h2
`define WM_TOP_VAR      2'h3
`define CEIL_FIX8       16'h00FF
`define CEIL_FIX9       16'h01FF
`define CEIL_FIX10      16'h03FF
`define CNT_BOTTOM      16'h0000
`define CNT_MAX         16'hFFFF
`define PRESCALE_MAX    10'h3FF
`define FILTER_LEN      4
`define RESET_BYTE      8'h00
`define RESET_WORD      16'h0000
`define POWER_RESET     1'b1
`endif

/* File: hdl/edge_sync.v */
// Purpose: two-flop synchroniser with previous-value stage for edge detection
// Assumes: async input, pclk domain
// Notes:   first flop feeds only the second
`timescale 1ns/10ps
module edge_sync
(
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire din,
  output wire level,
  output wire rise,
  output wire fall
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else if (ce)
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign level = s2_r;
  assign rise  = s2_r & ~s3_r;
  assign fall  = ~s2_r & s3_r;
endmodule // edge_sync

/* File: verification/timer16_core_props.sv */
// Purpose: port checks for timer16_core
// Assumes: ce held high
// Notes:   bound from the bench top
`timescale 1ns/10ps
`include "timer16_defs.vh"
module timer16_core_props
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        wave_out_a,
  input wire        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire  rd_setup = psel && !penable && !pwrite;
  wire  wr_acc   = psel && penable && pwrite && pready;
  logic wa_r;
  // =====
  // level of wave A when a force was written
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      wa_r <= 1'b0;
    else if (wr_acc && paddr == `OFS_CTRL_C)
      wa_r <= wave_out_a;
  a_ready_high: assert property (pready) else $error("pready low");
  a_no_slverr: assert property (psel && penable |-> !pslverr) else $error("slverr");
  a_rdata_upper: assert property (prdata[31:8] == 24'h00_0000)
    else $error("upper read bits");
  a_unmapped_zero: assert property (rd_setup && paddr > `OFS_POWER |=> prdata == 0)
    else $error("unmapped read");
  a_rdata_stands: assert property (!rd_setup |=> $stable(prdata))
    else $error("read data moved");
  a_mask_quiet: assert property (wr_acc && paddr == `OFS_MASK && pwdata[3:0] == 4'h0
    |=> !irq [*2]) else $error("irq while masked");
  a_reset_quiet: assert property ($rose(presetn) |-> !wave_out_a && !irq)
    else $error("outputs after reset");
  a_force_wave: assert property (wr_acc && paddr == `OFS_CTRL_C && pwdata[0]
    |-> ##[1:3] wave_out_a != wa_r) else $error("wave A not forced");
endmodule // timer16_core_props

/* File: verification/apb_cpu.sv */
// Purpose: processor side bus master model
// Assumes: pready sampled at rising edge
// Notes:   16-bit values go as two byte transfers
`timescale 1ns/10ps
module apb_cpu
(
  input  wire         pclk,
  input  wire  [31:0] prdata,
  input  wire         pready,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // =====
  // one byte transfer; released data is scrambled
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
  // single master, so no handler can slip between the two bytes
  task automatic wr16(input logic [11:0] lo, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, lo + 12'h004, v[15:8], q);
    xfer(1'b1, lo, v[7:0], q);
  endtask
  task automatic rd16(input logic [11:0] lo, output logic [15:0] v);
    logic [7:0] l;
    logic [7:0] h;
    xfer(1'b0, lo, 8'h00, l);
    xfer(1'b0, lo + 12'h004, 8'h00, h);
    v = {h, l};
  endtask
endmodule // apb_cpu

/* File: verification/timer16_core_and_byte_access_tb.sv */
// Purpose: directed bench for timer16_core
// Assumes: timer16_defs.vh on include path
// Notes:   one bus master model drives all accesses
`timescale 1ns/10ps
`include "timer16_defs.vh"
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module timer16_core_and_byte_access_tb;
  logic        pclk;
  logic        presetn;
  logic        cap_pin;
  logic        cmp_out;
  logic        ext_pin;
  wire         psel;
  wire         penable;
  wire         pwrite;
  wire  [11:0] paddr;
  wire  [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         wa;
  wire         wb;
  wire         irq;
  logic [15:0] v;
  logic [1:0]  w;
  int          n_fail;
  int          num_checks;
  int          cycles;
  apb_cpu cpu (.pclk(pclk), .prdata(prdata), .pready(pready), .psel(psel), .penable(penable),
               .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  timer16_core dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
                    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                    .pready(pready), .pslverr(), .capture_input_pin(cap_pin),
                    .comparator_out(cmp_out), .ext_count_pin(ext_pin), .wave_out_a(wa),
                    .wave_out_b(wb), .irq(irq));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic c8(input string nm, input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    cpu.xfer(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask
  task automatic c16(input string nm, input logic [11:0] a, input logic [15:0] e);
    logic [15:0] q;
    cpu.rd16(a, q);
    `CHK(nm, e, q)
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      ext_pin <= 1'b1;
      tick(4);
      ext_pin <= 1'b0;
      tick(4);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // =====
  // hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      results();
    end
  end
  initial
  begin
    presetn = 1'b0;
    cap_pin = 1'b0;
    cmp_out = 1'b0;
    ext_pin = 1'b0;
    tick(12);
    presetn <= 1'b1;
    c16("cnt", `OFS_CNT_L, 16'h0000);
    c16("cmpa", `OFS_CMPA_L, 16'h0000);
    c8("flag", `OFS_FLAG, 8'h00);
    c8("mask", `OFS_MASK, 8'h00);
    c8("ctrl_b", `OFS_CTRL_B, 8'h00);
    wr(`OFS_POWER, 8'h00);
    wr(`OFS_CTRL_A, 8'hA5);
    c8("ctrl_a", `OFS_CTRL_A, 8'hA5);
    wr(12'h03C, 8'h5A);
    c8("unmapped", 12'h03C, 8'h00);
    done("registers");
    cpu.wr16(`OFS_CNT_L, 16'h1234);
    tick(20);
    c16("cnt", `OFS_CNT_L, 16'h1234);
    c8("cnt_l", `OFS_CNT_L, 8'h34);
    wr(`OFS_CMPA_H, 8'hAB);
    c8("cnt_h", `OFS_CNT_H, 8'hAB);
    cpu.wr16(`OFS_CMPA_L, 16'h5566);
    wr(`OFS_CNT_H, 8'h77);
    c16("cmpa", `OFS_CMPA_L, 16'h5566);
    c8("cnt_h", `OFS_CNT_H, 8'h77);
    done("holding");
    w = {wb, wa};
    wr(`OFS_CTRL_C, 8'h03);
    tick(3);
    `CHK("wave", ~w, {wb, wa})
    c8("ctrl_c", `OFS_CTRL_C, 8'h00);
    done("force");
    wr(`OFS_MASK, 8'h02);
    cpu.wr16(`OFS_CMPA_L, 16'h0010);
    cpu.wr16(`OFS_CMPB_L, 16'h0020);
    cpu.wr16(`OFS_CNT_L, 16'h0000);
    wr(`OFS_CTRL_B, `CS_DIV1);
    tick(700);
    wr(`OFS_CTRL_B, `CS_OFF);
    c8("flag", `OFS_FLAG, 8'h07);
    `CHK("irq", 1'b1, irq)
    wr(`OFS_MASK, 8'h00);
    tick(1);
    `CHK("irq", 1'b0, irq)
    wr(`OFS_MASK, 8'h02);
    cpu.rd16(`OFS_CNT_L, v);
    `CHK("ceiling", 1'b1, v <= `CEIL_FIX8)
    tick(10);
    c16("cnt", `OFS_CNT_L, v);
    wr(`OFS_FLAG, 8'h0F);
    c8("flag", `OFS_FLAG, 8'h00);
    `CHK("irq", 1'b0, irq)
    done("count");
    wr(`OFS_CTRL_B, 8'h20);
    cpu.wr16(`OFS_CNT_L, 16'h0321);
    wr(`OFS_FLAG, 8'h0F);
    cap_pin <= 1'b1;
    tick(8);
    c16("cap", `OFS_CAP_L, 16'h0321);
    c8("flag", `OFS_FLAG, 8'h08);
    wr(`OFS_CTRL_B, 8'hA0);
    cpu.wr16(`OFS_CNT_L, 16'h0456);
    wr(`OFS_FLAG, 8'h0F);
    cmp_out <= 1'b1;
    tick(8);
    c16("cap", `OFS_CAP_L, 16'h0456);
    c8("flag", `OFS_FLAG, 8'h08);
    done("capture");
    cap_pin <= 1'b0;
    wr(`OFS_CTRL_B, 8'h60);
    cpu.wr16(`OFS_CNT_L, 16'h0789);
    wr(`OFS_FLAG, 8'h0F);
    cap_pin <= 1'b1;
    tick(2);
    cap_pin <= 1'b0;
    tick(6);
    c16("spike", `OFS_CAP_L, 16'h0456);
    c8("flag", `OFS_FLAG, 8'h00);
    cap_pin <= 1'b1;
    tick(10);
    c16("cap", `OFS_CAP_L, 16'h0789);
    c8("flag", `OFS_FLAG, 8'h08);
    done("filter");
    wr(`OFS_CTRL_B, `CS_EXT_RISE);
    cpu.wr16(`OFS_CNT_L, 16'h0000);
    pulse(5);
    c16("cnt", `OFS_CNT_L, 16'h0005);
    wr(`OFS_CTRL_B, `CS_EXT_FALL);
    pulse(3);
    c16("cnt", `OFS_CNT_L, 16'h0008);
    done("external");
    cpu.wr16(`OFS_CNT_L, 16'h0000);
    wr(`OFS_CTRL_B, `CS_DIV8);
    tick(80);
    wr(`OFS_CTRL_B, `CS_OFF);
    cpu.rd16(`OFS_CNT_L, v);
    `CHK("div8", 1'b1, v >= 16'd10 && v <= 16'd11)
    done("prescaler");
    cpu.wr16(`OFS_CNT_L, 16'h0000);
    w = {wb, wa};
    wr(`OFS_CTRL_B, 8'h19);
    tick(100);
    wr(`OFS_CTRL_B, 8'h18);
    cpu.rd16(`OFS_CNT_L, v);
    `CHK("top_var", 1'b1, v <= 16'h0010)
    `CHK("wave_a", w[0], wa)
    done("variable ceiling");
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    c16("cnt", `OFS_CNT_L, 16'h0000);
    c8("flag", `OFS_FLAG, 8'h00);
    c8("ctrl_b", `OFS_CTRL_B, 8'h00);
    wr(`OFS_CTRL_B, `CS_DIV1);
    tick(10);
    c16("cnt", `OFS_CNT_L, 16'h0000);
    done("reset");
    results();
  end
endmodule // timer16_core_and_byte_access_tb
bind timer16_core timer16_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wave_out_a(wave_out_a), .irq(irq));
